// ===== rtl/mem_map_defines.svh
// Address map constants for the memory map decoder
`ifndef MEM_MAP_DEFINES_SVH
`define MEM_MAP_DEFINES_SVH

`define PAGE_W            7
`define PROG_W            23
`define PAGE_RESET        16'h0000
`define PAGE_REG_ADDR     16'h001e
`define MODE_REG_ADDR     16'h001c
`define OVERLAY_BIT       5
`define ROM_OFF_BIT       6
`define RAM_TO_DATA_BIT   3
`define LOW_RAM_LO        16'h0080
`define LOW_RAM_HI        16'h7fff
`define HIGH_RAM_LO       16'h8000
`define HIGH_RAM_HI       16'hffff
`define HIGH_RAM_PAGE     7'h01
`define ROM_PAGE          7'h00
`define ROM_LO            16'hc000
`define ROM_HI            16'hffff
`define TAB_LO            16'hc000
`define TAB_HI            16'hd4ff
`define BOOT_LO           16'hf800
`define BOOT_HI           16'hfbff
`define FACT_LO           16'hff00
`define FACT_HI           16'hff7f
`define VEC_LO            16'hff80
`define VEC_HI            16'hffff
`define BLK_OFF_W         13
`define START_ADDR        16'hff80

`endif

// ===== rtl/mem_map_pkg.sv
// Types shared by the memory map decoder files
package mem_map_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0] {
        ROM_AREA_NONE    = 3'h0,
        ROM_AREA_TABLES  = 3'h1,
        ROM_AREA_BOOT    = 3'h2,
        ROM_AREA_FACTORY = 3'h3,
        ROM_AREA_VECTORS = 3'h4,
        ROM_AREA_OTHER   = 3'h5
    } rom_area_e;
endpackage

// ===== rtl/map_decode.sv
// Combinational address decode for data and program space
`timescale 1ns/1ps
`include "mem_map_defines.svh"
module map_decode
    import mem_map_pkg::*;
(
    input  wire logic [`PROG_W-1:0] prog_full,
    input  wire word_t              data_addr,
    input  wire logic               overlay_en,
    input  wire logic               ram_to_data,
    input  wire logic               rom_off,
    output logic      [7:0]         data_blk,
    output logic                    data_reg_hit,
    output logic      [7:0]         prog_blk,
    output logic                    prog_rom,
    output rom_area_e               rom_area
);
    function automatic logic in_range(word_t a, word_t lo, word_t hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] blk_onehot(word_t a);
        return 8'h01 << a[15:`BLK_OFF_W];
    endfunction

    word_t                  pa;
    logic [`PAGE_W-1:0]     pg;

    assign pa = prog_full[15:0];
    assign pg = prog_full[`PROG_W-1:16];

    always_comb begin
        data_blk     = 8'h00;
        prog_blk     = 8'h00;
        prog_rom     = 1'b0;
        rom_area     = ROM_AREA_NONE;
        data_reg_hit = (data_addr == `PAGE_REG_ADDR) ||
                       (data_addr == `MODE_REG_ADDR);
        if (in_range(data_addr, `LOW_RAM_LO, `LOW_RAM_HI)) begin
            data_blk = blk_onehot(data_addr); // RULE13 RULE1 RULE11
        end else if (ram_to_data &&
                     in_range(data_addr, `HIGH_RAM_LO, `HIGH_RAM_HI)) begin
            data_blk = blk_onehot(data_addr); // RULE14
        end
        // ROM answers program space only, never data
        if (!rom_off && pg == `ROM_PAGE &&
            in_range(pa, `ROM_LO, `ROM_HI)) begin
            prog_rom = 1'b1; // RULE7 RULE18
            if (in_range(pa, `TAB_LO, `TAB_HI)) begin
                rom_area = ROM_AREA_TABLES; // RULE9
            end else if (in_range(pa, `BOOT_LO, `BOOT_HI)) begin
                rom_area = ROM_AREA_BOOT; // RULE9
            end else if (in_range(pa, `FACT_LO, `FACT_HI)) begin
                rom_area = ROM_AREA_FACTORY; // RULE10
            end else if (in_range(pa, `VEC_LO, `VEC_HI)) begin
                rom_area = ROM_AREA_VECTORS; // RULE9
            end else begin
                rom_area = ROM_AREA_OTHER;
            end
        end
        if (overlay_en && in_range(pa, `LOW_RAM_LO, `LOW_RAM_HI)) begin
            prog_blk = blk_onehot(pa); // RULE13 RULE2
        end else if (pg == `HIGH_RAM_PAGE &&
                     in_range(pa, `HIGH_RAM_LO, `HIGH_RAM_HI)) begin
            prog_blk = blk_onehot(pa); // RULE14 RULE2
        end
    end
endmodule

// ===== rtl/memory_map_decoder.sv
// Memory map decoder: data/program steering and page register
// Overview of operation
// (RULE1) Data space 64K words; outside RAM goes external
// (RULE2) Program hits in mapped cells served internally
// (RULE3) On-chip accesses need no wait states
// (RULE4) Program space extends to 8192K words
// (RULE5) 128 pages of 64K selected by page
// (RULE6) Page register at 001Eh, reset to zero
// (RULE7) 16K ROM decodes only in program space
// (RULE8) Pin low at reset starts at FF80h
// (RULE9) ROM holds tables, bootloader, vector table
// (RULE10) Custom ROM leaves FF00h-FF7Fh for factory test
// (RULE11) RAM is eight 8K-word blocks
// (RULE12) Block serves two reads or read plus write
// (RULE13) Blocks 0-3 in data; overlay adds program
// (RULE14) Blocks 4-7 in program; flag adds data
// (RULE15) ROM select pin sampled only at reset
// (RULE16) Overlay flag is mode bit 5, resets zero
// (RULE17) Page sits above 16-bit in-page address
// (RULE18) ROM off sends ROM range fetches external
`timescale 1ns/1ps
`include "mem_map_defines.svh"
module memory_map_decoder
    import mem_map_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               rom_map_select_pin,
    input  wire word_t              data_addr,
    input  wire logic               data_rd,
    input  wire logic               data_wr,
    input  wire word_t              data_wdata,
    input  wire word_t              prog_addr,
    input  wire logic               prog_fetch,
    output logic      [7:0]         data_ram_sel,
    output logic                    data_ram_we,
    output logic      [`BLK_OFF_W-1:0] data_blk_off,
    output logic                    data_ext_req,
    output logic                    data_zero_wait,
    output word_t                   reg_rdata,
    output logic                    reg_rd_valid,
    output logic      [7:0]         prog_ram_sel,
    output logic                    prog_rom_sel,
    output rom_area_e               rom_area,
    output logic      [`BLK_OFF_W-1:0] prog_blk_off,
    output logic                    prog_ext_req,
    output logic                    prog_zero_wait,
    output logic      [`PROG_W-1:0] ext_prog_addr,
    output logic                    ram_overlay_enable,
    output logic                    program_ram_to_data_enable,
    output logic                    rom_map_select,
    output logic                    boot_from_rom,
    output word_t                   start_fetch_addr
);
    word_t                  program_page_select;
    word_t                  next_page;
    logic                   next_overlay;
    logic                   next_ram_to_data;
    logic                   next_rom_off;
    logic                   next_boot;
    word_t                  next_start;
    logic [`PROG_W-1:0]     prog_full;
    logic [7:0]             dec_data_blk;
    logic                   dec_reg_hit;
    logic [7:0]             dec_prog_blk;
    logic                   dec_prog_rom;
    rom_area_e              dec_rom_area;
    word_t                  mode_word;

    // Page widens the 16-bit in-page address to 23 lines
    assign prog_full = {program_page_select[`PAGE_W-1:0],
                        prog_addr}; // RULE17 RULE4 RULE5

    map_decode u_decode (
        .prog_full    (prog_full),
        .data_addr    (data_addr),
        .overlay_en   (ram_overlay_enable),
        .ram_to_data  (program_ram_to_data_enable),
        .rom_off      (rom_map_select),
        .data_blk     (dec_data_blk),
        .data_reg_hit (dec_reg_hit),
        .prog_blk     (dec_prog_blk),
        .prog_rom     (dec_prog_rom),
        .rom_area     (dec_rom_area)
    );

    always_comb begin
        mode_word                   = 16'h0000;
        mode_word[`OVERLAY_BIT]     = ram_overlay_enable;
        mode_word[`ROM_OFF_BIT]     = rom_map_select;
        mode_word[`RAM_TO_DATA_BIT] = program_ram_to_data_enable;
    end

    // Control registers
    always_comb begin
        next_page        = program_page_select;
        next_overlay     = ram_overlay_enable;
        next_ram_to_data = program_ram_to_data_enable;
        next_rom_off     = rom_map_select;
        next_boot        = boot_from_rom;
        next_start       = start_fetch_addr;
        if (sys_rst) begin
            next_page        = `PAGE_RESET; // RULE6
            next_overlay     = 1'b0; // RULE16
            next_ram_to_data = 1'b0;
            // Pin is caught only while reset is held
            next_rom_off     = rom_map_select_pin; // RULE15
            next_boot        = ~rom_map_select_pin; // RULE8
            next_start       = `START_ADDR; // RULE8
        end else if (data_wr && data_addr == `PAGE_REG_ADDR) begin
            next_page = data_wdata; // RULE6
        end else if (data_wr && data_addr == `MODE_REG_ADDR) begin
            next_overlay     = data_wdata[`OVERLAY_BIT]; // RULE16
            next_rom_off     = data_wdata[`ROM_OFF_BIT]; // RULE15
            next_ram_to_data = data_wdata[`RAM_TO_DATA_BIT]; // RULE14
        end
    end

    always_ff @(posedge ref_clk) begin
        program_page_select        <= next_page;
        ram_overlay_enable         <= next_overlay;
        program_ram_to_data_enable <= next_ram_to_data;
        rom_map_select             <= next_rom_off;
        boot_from_rom              <= next_boot;
        start_fetch_addr           <= next_start;
    end

    // Registered decode outputs
    logic [7:0]             next_d_sel;
    logic                   next_d_we;
    logic                   next_d_ext;
    logic                   next_d_zw;
    word_t                  next_rdata;
    logic                   next_rvalid;
    logic [7:0]             next_p_sel;
    logic                   next_p_rom;
    rom_area_e              next_area;
    logic                   next_p_ext;
    logic                   next_p_zw;
    logic [`PROG_W-1:0]     next_ext_addr;

    always_comb begin
        next_d_sel    = 8'h00;
        next_d_we     = 1'b0;
        next_d_ext    = 1'b0;
        next_d_zw     = 1'b0;
        next_rdata    = reg_rdata;
        next_rvalid   = 1'b0;
        next_p_sel    = 8'h00;
        next_p_rom    = 1'b0;
        next_area     = ROM_AREA_NONE;
        next_p_ext    = 1'b0;
        next_p_zw     = 1'b0;
        next_ext_addr = ext_prog_addr;
        if (sys_rst) begin
            next_rdata    = 16'h0000;
            next_ext_addr = '0;
        end else begin
            if (data_rd || data_wr) begin
                if (dec_reg_hit) begin
                    next_d_zw   = 1'b1;
                    next_rvalid = data_rd;
                    next_rdata  = (data_addr == `PAGE_REG_ADDR) ?
                                  program_page_select : mode_word;
                end else if (dec_data_blk != 8'h00) begin
                    // Data port may share a block with a fetch
                    next_d_sel = dec_data_blk; // RULE12 RULE1
                    next_d_we  = data_wr; // RULE12
                    next_d_zw  = 1'b1; // RULE3
                end else begin
                    next_d_ext = 1'b1; // RULE1
                end
            end
            if (prog_fetch) begin
                next_ext_addr = prog_full; // RULE17 RULE4
                if (dec_prog_rom) begin
                    next_p_rom = 1'b1; // RULE7 RULE8
                    next_area  = dec_rom_area; // RULE9
                    next_p_zw  = 1'b1; // RULE3
                end else if (dec_prog_blk != 8'h00) begin
                    next_p_sel = dec_prog_blk; // RULE2 RULE12
                    next_p_zw  = 1'b1; // RULE3
                end else begin
                    next_p_ext = 1'b1; // RULE2 RULE18
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        data_ram_sel   <= next_d_sel;
        data_ram_we    <= next_d_we;
        data_blk_off   <= data_addr[`BLK_OFF_W-1:0];
        data_ext_req   <= next_d_ext;
        data_zero_wait <= next_d_zw;
        reg_rdata      <= next_rdata;
        reg_rd_valid   <= next_rvalid;
        prog_ram_sel   <= next_p_sel;
        prog_rom_sel   <= next_p_rom;
        rom_area       <= next_area;
        prog_blk_off   <= prog_addr[`BLK_OFF_W-1:0];
        prog_ext_req   <= next_p_ext;
        prog_zero_wait <= next_p_zw;
        ext_prog_addr  <= next_ext_addr;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_page_write: assert property ( // RULE6
        data_wr && data_addr == `PAGE_REG_ADDR |=>
        program_page_select == $past(data_wdata))
        else $error("page register write lost");
    a_page_reset: assert property ( // RULE6
        $fell(sys_rst) |-> program_page_select == 16'h0000 &&
        !ram_overlay_enable)
        else $error("page or overlay not cleared by reset");
    a_pin_sample: assert property ( // RULE15
        $fell(sys_rst) |-> rom_map_select == $past(rom_map_select_pin)
        && boot_from_rom == !rom_map_select)
        else $error("rom select not taken from pin");
    a_ext_addr_form: assert property ( // RULE17
        prog_fetch |=> ext_prog_addr ==
        {$past(program_page_select[6:0]), $past(prog_addr)})
        else $error("extended address misformed");
    a_data_external: assert property ( // RULE1
        data_rd && data_addr[15] && !program_ram_to_data_enable |=>
        data_ext_req && data_ram_sel == 8'h00 && !data_zero_wait)
        else $error("high data address not sent external");
    a_data_low_ram: assert property ( // RULE13
        data_rd && data_addr >= 16'h0080 && !data_addr[15] |=>
        data_ram_sel == (8'h01 << $past(data_addr[15:13])) &&
        data_zero_wait && !data_ext_req)
        else $error("low data RAM not served internally");
    a_rom_prog_only: assert property ( // RULE7
        prog_rom_sel |-> $past(prog_fetch) && !$past(rom_map_select))
        else $error("ROM selected without a program fetch");
    a_rom_disabled: assert property ( // RULE18
        prog_fetch && rom_map_select && program_page_select == 16'h0000
        && prog_addr >= 16'hc000 |=> prog_ext_req && !prog_rom_sel)
        else $error("disabled ROM still answered");
    a_no_overlay: assert property ( // RULE13
        prog_fetch && !ram_overlay_enable && !prog_addr[15] |=>
        prog_ext_req && prog_ram_sel == 8'h00)
        else $error("program fetch hit RAM without overlay");
    a_page1_blocks: assert property ( // RULE14
        prog_fetch && program_page_select == 16'h0001 && prog_addr[15]
        |=> prog_ram_sel[7:4] != 4'h0 && prog_zero_wait)
        else $error("page one high RAM not served");
    a_dual_port: assert property ( // RULE12
        data_wr && prog_fetch && ram_overlay_enable &&
        data_addr >= 16'h0080 && !data_addr[15] &&
        prog_addr[15:13] == data_addr[15:13] && prog_addr >= 16'h0080
        |=> (data_ram_sel & prog_ram_sel) != 8'h00 && data_ram_we)
        else $error("shared block did not serve both ports");

    c_rom_vector: cover property (
        prog_fetch ##1 prog_rom_sel && rom_area == ROM_AREA_VECTORS);
    c_program_ram_to_data_enable_data: cover property (
        program_ram_to_data_enable && data_rd ##1 data_ram_sel[7:4] != 0);
    c_page_change: cover property (
        data_wr && data_addr == `PAGE_REG_ADDR ##1 prog_fetch);
endmodule

// ===== tb/ext_bus_model.sv
// External memory bus model: records off-chip program and data requests
`timescale 1ns/1ps
module ext_bus_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        prog_ext_req,
    input  wire logic        data_ext_req,
    input  wire logic [22:0] ext_prog_addr,
    output logic      [22:0] last_ext_addr,
    output logic      [7:0]  ext_count
);
    logic [22:0] next_last_ext_addr;
    logic [7:0]  next_ext_count;

    // The address bus only means something while a fetch goes off chip
    always_comb begin
        next_last_ext_addr = last_ext_addr;
        next_ext_count     = ext_count;
        if (prog_ext_req)
            next_last_ext_addr = ext_prog_addr;
        if (prog_ext_req || data_ext_req)
            next_ext_count = ext_count + 8'h01;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_ext_addr <= 23'h000000;
            ext_count     <= 8'h00;
        end else begin
            last_ext_addr <= next_last_ext_addr;
            ext_count     <= next_ext_count;
        end
    end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb
    import mem_map_pkg::*;
;
    logic        ref_clk = 0, sys_rst = 1, rom_map_select_pin = 0;
    logic        data_rd = 0, data_wr = 0, prog_fetch = 0;
    word_t       data_addr = '0, data_wdata = '0, prog_addr = '0;
    word_t       reg_rdata, start_fetch_addr;
    logic [7:0]  data_ram_sel, prog_ram_sel, ext_count;
    logic [12:0] data_blk_off, prog_blk_off;
    logic        data_ram_we, data_ext_req, data_zero_wait, reg_rd_valid;
    logic        prog_rom_sel, prog_ext_req, prog_zero_wait;
    logic        ram_overlay_enable, program_ram_to_data_enable;
    logic        rom_map_select, boot_from_rom;
    logic [22:0] ext_prog_addr, last_ext_addr;
    rom_area_e   rom_area;
    int          fails = 0, comparisons = 0;
    // Data addresses and the block each should hit; zero means off chip
    logic [15:0] dadr [10] = '{16'h0080, 16'h1fff, 16'h2000, 16'h4000,
        16'h6000, 16'h7fff, 16'h0000, 16'h0040, 16'h9000, 16'hc000};
    logic [7:0]  dsel [10] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00};
    // ROM edges of each area and the area code expected there
    logic [15:0] padr [9] = '{16'hc000, 16'hd4ff, 16'hd500, 16'hf800,
        16'hfbff, 16'hff00, 16'hff7f, 16'hff80, 16'hffff};
    logic [2:0]  parea [9] = '{3'h1, 3'h1, 3'h5, 3'h2, 3'h2, 3'h3, 3'h3,
        3'h4, 3'h4};

    always #2 ref_clk = ~ref_clk;

    memory_map_decoder u_dut (.ref_clk, .sys_rst, .rom_map_select_pin,
        .data_addr, .data_rd, .data_wr, .data_wdata, .prog_addr, .prog_fetch,
        .data_ram_sel, .data_ram_we, .data_blk_off, .data_ext_req,
        .data_zero_wait, .reg_rdata, .reg_rd_valid, .prog_ram_sel,
        .prog_rom_sel, .rom_area, .prog_blk_off, .prog_ext_req,
        .prog_zero_wait, .ext_prog_addr, .ram_overlay_enable,
        .program_ram_to_data_enable, .rom_map_select, .boot_from_rom,
        .start_fetch_addr);

    ext_bus_model u_ext (.ref_clk, .sys_rst, .prog_ext_req, .data_ext_req,
        .ext_prog_addr, .last_ext_addr, .ext_count);

    task automatic chk(input string nm, input logic [22:0] exp,
                       input logic [22:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic rst(input logic pin);
        rom_map_select_pin = pin;
        sys_rst = 1;
        repeat (10) @(posedge ref_clk);
        #1 sys_rst = 0;
    endtask

    // One access cycle; the answer is visible when the task returns
    task automatic cyc(input logic [15:0] da, input logic rd, input logic wr,
                       input logic [15:0] wd, input logic [15:0] pa,
                       input logic pf);
        @(posedge ref_clk);
        #1;
        data_addr = da;
        data_rd = rd;
        data_wr = wr;
        data_wdata = wd;
        prog_addr = pa;
        prog_fetch = pf;
        @(posedge ref_clk);
        #1;
        data_rd = 0;
        data_wr = 0;
        prog_fetch = 0;
    endtask

    task automatic rd(input logic [15:0] a);
        cyc(a, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        cyc(a, 1'b0, 1'b1, d, 16'h0000, 1'b0);
    endtask

    task automatic ft(input logic [15:0] a);
        cyc(16'h0000, 1'b0, 1'b0, 16'h0000, a, 1'b1);
    endtask

    initial begin
        #40000;
        fails++;
        stop_test();
    end

    initial begin
        rst(1'b0);
        chk("rom_map_select", 0, rom_map_select);
        chk("boot_from_rom", 1, boot_from_rom);
        chk("start_fetch_addr", 16'hff80, start_fetch_addr);
        chk("ram_overlay_enable", 0, ram_overlay_enable);
        rd(16'h001e);
        chk("reg_rd_valid", 1, reg_rd_valid);
        chk("page reset", 16'h0000, reg_rdata);
        for (int i = 0; i < 10; i++) begin
            rd(dadr[i]);
            chk("data_ram_sel", dsel[i], data_ram_sel);
            chk("data_ext_req", dsel[i] == 0, data_ext_req);
            chk("data_zero_wait", dsel[i] != 0, data_zero_wait);
        end
        rd(16'h2345);
        chk("data_blk_off", 13'h0345, data_blk_off);
        for (int i = 0; i < 9; i++) begin
            ft(padr[i]);
            chk("prog_rom_sel", 1, prog_rom_sel);
            chk("rom_area", parea[i], rom_area);
            chk("prog_zero_wait", 1, prog_zero_wait);
        end
        ft(16'h0080);
        chk("prog_ext_req", 1, prog_ext_req);
        wr(16'h001c, 16'h0020);
        chk("ram_overlay_enable", 1, ram_overlay_enable);
        ft(16'h2000);
        chk("prog_ram_sel", 8'h02, prog_ram_sel);
        // Data read-write and a fetch hitting the same block in one cycle
        cyc(16'h0080, 1'b1, 1'b1, 16'h1234, 16'h0100, 1'b1);
        chk("data_ram_sel", 8'h01, data_ram_sel);
        chk("data_ram_we", 1, data_ram_we);
        chk("prog_ram_sel", 8'h01, prog_ram_sel);
        wr(16'h001e, 16'h0001);
        rd(16'h001e);
        chk("page", 16'h0001, reg_rdata);
        ft(16'h9000);
        chk("prog_ram_sel", 8'h10, prog_ram_sel);
        chk("prog_blk_off", 13'h1000, prog_blk_off);
        chk("ext_prog_addr", 23'h019000, ext_prog_addr);
        // Page value above 7Fh: all bits stored, low seven select the page
        wr(16'h001e, 16'h00ff);
        rd(16'h001e);
        chk("page", 16'h00ff, reg_rdata);
        // Above the overlay window and off page 1, so it must go off chip
        ft(16'h8234);
        chk("prog_ext_req", 1, prog_ext_req);
        chk("ext_prog_addr", 23'h7f8234, ext_prog_addr);
        // The bus model takes the address one edge after the request
        @(posedge ref_clk);
        #1;
        chk("last_ext_addr", 23'h7f8234, last_ext_addr);
        rd(16'he000);
        chk("data_ext_req", 1, data_ext_req);
        wr(16'h001c, 16'h0028);
        chk("program_ram_to_data_enable", 1,
            program_ram_to_data_enable);
        rd(16'he000);
        chk("data_ram_sel", 8'h80, data_ram_sel);
        rd(16'h001c);
        chk("mode", 16'h0028, reg_rdata);
        wr(16'h001c, 16'h0068);
        wr(16'h001e, 16'h0000);
        chk("rom_map_select", 1, rom_map_select);
        ft(16'hff80);
        chk("prog_rom_sel", 0, prog_rom_sel);
        @(posedge ref_clk);
        #1;
        chk("last_ext_addr", 23'h00ff80, last_ext_addr);
        // Eight off-chip requests since reset: five data, three fetches
        chk("ext_count", 8'h08, ext_count);
        rst(1'b1);
        chk("rom_map_select", 1, rom_map_select);
        chk("boot_from_rom", 0, boot_from_rom);
        rd(16'h001e);
        chk("page reset", 16'h0000, reg_rdata);
        ft(16'hc000);
        chk("prog_ext_req", 1, prog_ext_req);
        chk("ram_overlay_enable", 0, ram_overlay_enable);
        stop_test();
    end
endmodule
